/* sscp_host.sv */
// host terminal model: serial sender and response receiver
`timescale 1ns/1ps
module sscp_host #(
  parameter int BIT_CYC = 4
) (
  input wire logic clk_i,
  output logic line_o,
  input wire logic line_i,
  output logic [7:0] got_o,
  output logic got_stb_o
);
  initial line_o = 1'b1;
  initial got_o = 8'h00;
  initial got_stb_o = 1'b0;
  task automatic idle(input int chars);
    repeat (chars * 10 * BIT_CYC) @(posedge clk_i);
  endtask
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      line_o <= f[i];
      repeat (BIT_CYC) @(posedge clk_i);
    end
  endtask
  // reply bytes collected from the module line
  always begin : rx
    logic [7:0] b;
    @(negedge line_i);
    repeat (BIT_CYC / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYC) @(posedge clk_i);
      b[i] = line_i;
    end
    repeat (BIT_CYC) @(posedge clk_i);
    got_o <= b;
    got_stb_o <= 1'b1;
    @(posedge clk_i);
    got_stb_o <= 1'b0;
  end
endmodule

/* sscp_pkg.sv */
// shared constants and types of the setup command parser
package sscp_pkg;
  localparam int CLK_HZ = 10_000_000;
  localparam int BAUD_DEF = 9600;
  localparam int BIT_CYC_DEF = CLK_HZ / BAUD_DEF;
  localparam int CHAR_BITS = 10;
  localparam int GAP_CAP_MS = 170;
  localparam int GAP_CAP_CYC_DEF = (CLK_HZ / 1000) * GAP_CAP_MS;
  localparam logic [7:0] GAP_MIN = 8'h03;
  localparam logic [7:0] GAP_RST = 8'h03;
  localparam logic [1:0] SEQ_LAST = 2'h2;

  localparam logic [4:0] OFS_CTRL = 5'h00;
  localparam logic [4:0] OFS_STAT = 5'h04;
  localparam logic [4:0] OFS_CMD = 5'h08;
  localparam logic [4:0] OFS_RESP = 5'h0c;

  localparam int CTRL_EN = 0;
  localparam int CTRL_CRLF = 1;
  localparam int CTRL_AUX = 2;
  localparam int CTRL_GAP = 8;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic CTRL_CRLF_RST = 1'b1;
  localparam logic CTRL_AUX_RST = 1'b0;
  localparam int STAT_PEND = 0;
  localparam int STAT_PORT = 1;
  localparam int STAT_FORCED = 2;
  localparam int STAT_OVF = 3;
  localparam int STAT_LEN = 8;
  localparam int CMD_VALID = 8;
  localparam int RESP_LAST = 8;

  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_MINUS = 8'h2d;
  localparam logic [7:0] CH_S = 8'h53;
  localparam logic [7:0] CH_L = 8'h4c;
  localparam logic [7:0] CH_O = 8'h4f;
  localparam logic [7:0] CH_K = 8'h4b;

  typedef enum logic [2:0] {
    P_IDLE = 3'b000,
    P_FIRST = 3'b001,
    P_CMD = 3'b010,
    P_DATA = 3'b011,
    P_HOLD = 3'b100,
    P_SKIP = 3'b101
  } sscp_pst_t;

  typedef enum logic [2:0] {
    T_IDLE = 3'b000,
    T_K = 3'b001,
    T_CR = 3'b010,
    T_LF = 3'b011
  } sscp_tst_t;
endpackage

/* sscp_rx.sv */
// serial receiver with idle gap timer for one host port
`timescale 1ns/1ps
module sscp_rx import sscp_pkg::*; #(
  parameter int BIT_CYC = BIT_CYC_DEF
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic line_i,
  input wire logic [23:0] gap_cyc_i,
  sscp_rx_if.src rx
);
  localparam logic [15:0] HALF = 16'(BIT_CYC / 2);
  localparam logic [15:0] FULL = 16'(BIT_CYC - 1);
  typedef struct packed {
    logic prev;
    logic [23:0] idle;
    logic gap;
    logic busy;
    logic [3:0] bitn;
    logic [15:0] div;
    logic [7:0] sh;
    logic [7:0] data;
    logic stb;
  } sscp_rxs_t;
  sscp_rxs_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    s_d.stb = 1'b0;
    s_d.prev = line_i;
    if (line_i != s_q.prev) begin
      s_d.idle = '0;
      s_d.gap = 1'b0;
    end else if (s_q.idle < gap_cyc_i) begin
      s_d.idle = s_q.idle + 24'h1;
    end else begin
      s_d.gap = 1'b1;
    end
    if (!s_q.busy) begin
      if (!line_i) begin
        s_d.busy = 1'b1;
        s_d.div = HALF;
        s_d.bitn = 4'h0;
      end
    end else if (s_q.div != 16'h0) begin
      s_d.div = s_q.div - 16'h1;
    end else begin
      s_d.div = FULL;
      s_d.bitn = s_q.bitn + 4'h1;
      if (s_q.bitn == 4'h0) begin
        if (line_i) begin
          s_d.busy = 1'b0;
        end
      end else if (s_q.bitn < 4'h9) begin
        s_d.sh = {line_i, s_q.sh[7:1]};
      end else begin
        s_d.busy = 1'b0;
        s_d.data = s_q.sh;
        s_d.stb = line_i;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
      s_q.prev <= 1'b1;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign rx.data = s_q.data;
  assign rx.stb = s_q.stb;
  assign rx.gap = s_q.gap;

  a_edge_clears_gap: assert property (@(posedge clk_i) disable iff (!nrst_i)
    (ce_i && line_i != s_q.prev) |=> !s_q.gap)
    else $error("gap stayed high after a line edge");
endmodule

/* sscp_rx_if.sv */
// received byte and idle gap of one serial port
`timescale 1ns/1ps
interface sscp_rx_if;
  logic [7:0] data;
  logic stb;
  logic gap;
  modport src (output data, output stb, output gap);
  modport dst (input data, input stb, input gap);
endinterface

/* sscp_top.sv */
// setup command framing, forced mode and register slave
//
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module sscp_top import sscp_pkg::*; #(
  parameter int BIT_CYC = BIT_CYC_DEF,
  parameter int GAP_CAP_CYC = GAP_CAP_CYC_DEF,
  parameter int DEPTH = 32
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic host_to_module_line_i,
  output logic module_to_host_line_o,
  input wire logic auxiliary_host_to_module_line_i,
  output logic auxiliary_module_to_host_line_o,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [7:0] user_data_o,
  output logic user_valid_o,
  output logic radio_suspend_o,
  output logic reboot_o
);
  localparam int IW = $clog2(DEPTH);
  localparam int LW = IW + 1;
  localparam logic [LW-1:0] FULL_LEN = LW'(DEPTH);
  localparam logic [23:0] CHAR_CYC = 24'(CHAR_BITS * BIT_CYC);
  localparam logic [31:0] CAP = 32'(GAP_CAP_CYC);

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic cmd_en;
    logic crlf_en;
    logic aux_en;
    logic [7:0] gap_len;
    sscp_pst_t st;
    logic act;
    logic [1:0] gapq;
    logic [7:0] first;
    logic [1:0] plus;
    logic [1:0] minus;
    logic forced;
    logic reboot;
    logic hw_ok;
    logic oport;
    logic pend;
    logic cport;
    logic ovf;
    logic [LW-1:0] len;
    logic [LW-1:0] rdp;
    logic [DEPTH-1:0][7:0] cbuf;
    logic [7:0] udata;
    logic uvalid;
    logic upend;
    logic [7:0] ubyte2;
    sscp_tst_t ts;
    logic [8:0] slot;
    logic slot_v;
    logic [7:0] prevb;
    logic sw;
    logic done;
  } sscp_st_t;
  sscp_st_t s_q, s_d;

  sscp_rx_if rxp ();
  sscp_rx_if rxa ();
  logic [31:0] raw;
  logic [23:0] gap_cyc;
  logic [1:0] stb, gapl, gev, tx_rdy;
  logic [7:0] rb, tx_b, lastb, prevc;
  logic tx_v, fire, cmd_on, busy_slot;
  logic [31:0] ctrl_w, stat_w, cmd_w;

  assign raw = 32'(s_q.gap_len) * 32'(CHAR_CYC);
  assign gap_cyc = (raw > CAP) ? CAP[23:0] : raw[23:0];

  sscp_rx #(.BIT_CYC(BIT_CYC)) u_rxp (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .line_i(host_to_module_line_i),
    .gap_cyc_i(gap_cyc),
    .rx(rxp)
  );
  sscp_rx #(.BIT_CYC(BIT_CYC)) u_rxa (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .line_i(auxiliary_host_to_module_line_i),
    .gap_cyc_i(gap_cyc),
    .rx(rxa)
  );
  sscp_tx #(.BIT_CYC(BIT_CYC)) u_txp (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .data_i(tx_b),
    .valid_i(tx_v && !s_q.oport),
    .ready_o(tx_rdy[0]),
    .line_o(module_to_host_line_o)
  );
  sscp_tx #(.BIT_CYC(BIT_CYC)) u_txa (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .ce_i(ce_i),
    .data_i(tx_b),
    .valid_i(tx_v && s_q.oport),
    .ready_o(tx_rdy[1]),
    .line_o(auxiliary_module_to_host_line_o)
  );

  assign stb = {rxa.stb, rxp.stb};
  assign gapl = {rxa.gap, rxp.gap};
  assign gev = gapl & ~s_q.gapq;
  assign rb = s_q.act ? rxa.data : rxp.data;
  assign cmd_on = s_q.cmd_en || s_q.forced;
  assign lastb = s_q.cbuf[IW'(s_q.len - LW'(1))];
  assign prevc = s_q.cbuf[IW'(s_q.len - LW'(2))];
  assign fire = tx_v && tx_rdy[s_q.oport];
  assign busy_slot = avs_write_i && avs_address_i == OFS_RESP && s_q.slot_v;

  always_comb begin
    ctrl_w = '0;
    ctrl_w[CTRL_EN] = s_q.cmd_en;
    ctrl_w[CTRL_CRLF] = s_q.crlf_en;
    ctrl_w[CTRL_AUX] = s_q.aux_en;
    ctrl_w[CTRL_GAP +: 8] = s_q.gap_len;
    stat_w = '0;
    stat_w[STAT_PEND] = s_q.pend;
    stat_w[STAT_PORT] = s_q.cport;
    stat_w[STAT_FORCED] = s_q.forced;
    stat_w[STAT_OVF] = s_q.ovf;
    stat_w[STAT_LEN +: LW] = s_q.len;
    cmd_w = '0;
    cmd_w[CMD_VALID] = s_q.rdp < s_q.len;
    cmd_w[7:0] = s_q.cbuf[IW'(s_q.rdp)];
  end

  // response source: hardware OK or software bytes
  always_comb begin
    tx_v = 1'b1;
    tx_b = CH_LF;
    case (s_q.ts)
      T_IDLE: begin
        tx_v = s_q.hw_ok || s_q.slot_v;
        tx_b = s_q.hw_ok ? CH_O : s_q.slot[7:0];
      end
      T_K: tx_b = CH_K;
      T_CR: tx_b = CH_CR;
      default: tx_b = CH_LF;
    endcase
  end

  always_comb begin
    s_d = s_q;
    s_d.reboot = 1'b0;
    s_d.uvalid = 1'b0;
    s_d.done = 1'b0;
    s_d.gapq = gapl;
    if (s_q.upend) begin
      s_d.uvalid = 1'b1;
      s_d.udata = s_q.ubyte2;
      s_d.upend = 1'b0;
    end
    case (s_q.st)
      P_SKIP: if (gapl[s_q.act]) s_d.st = P_IDLE;
      P_IDLE: begin
        if (stb[0] || (stb[1] && s_q.aux_en)) begin
          s_d.act = !stb[0];
          s_d.first = stb[0] ? rxp.data : rxa.data;
          s_d.st = P_FIRST;
        end
      end
      P_FIRST: begin
        if (stb[s_q.act]) begin
          s_d.plus = 2'h0;
          s_d.minus = 2'h0;
          if (cmd_on && s_q.first == CH_S && rb == CH_L) begin
            s_d.cbuf[0] = CH_S;
            s_d.cbuf[1] = CH_L;
            s_d.len = LW'(2);
            s_d.ovf = 1'b0;
            s_d.st = P_CMD;
          end else if (!s_q.act) begin
            s_d.uvalid = 1'b1;
            s_d.udata = s_q.first;
            s_d.ubyte2 = rb;
            s_d.upend = 1'b1;
            s_d.st = P_DATA;
          end else begin
            s_d.st = P_SKIP;
          end
        end else if (gev[s_q.act]) begin
          s_d.st = P_IDLE;
          if (s_q.first == CH_PLUS) begin
            s_d.minus = 2'h0;
            if (s_q.plus == SEQ_LAST) begin
              s_d.plus = 2'h0;
              s_d.forced = 1'b1;
              s_d.hw_ok = 1'b1;
              s_d.oport = s_q.act;
            end else begin
              s_d.plus = s_q.plus + 2'h1;
            end
          end else if (s_q.first == CH_MINUS && s_q.forced) begin
            s_d.plus = 2'h0;
            if (s_q.minus == SEQ_LAST) begin
              s_d.minus = 2'h0;
              s_d.forced = 1'b0;
              s_d.reboot = 1'b1;
              s_d.hw_ok = 1'b1;
              s_d.oport = s_q.act;
            end else begin
              s_d.minus = s_q.minus + 2'h1;
            end
          end else begin
            s_d.plus = 2'h0;
            s_d.minus = 2'h0;
            s_d.uvalid = !s_q.act;
            s_d.udata = s_q.first;
          end
        end
      end
      P_CMD: begin
        if (stb[s_q.act]) begin
          if (s_q.len < FULL_LEN) begin
            s_d.cbuf[IW'(s_q.len)] = rb;
            s_d.len = s_q.len + LW'(1);
          end else begin
            s_d.ovf = 1'b1;
          end
        end else if (gev[s_q.act]) begin
          if (lastb == CH_LF && prevc == CH_CR) begin
            s_d.len = s_q.len - LW'(2);
          end else if (lastb == CH_CR) begin
            s_d.len = s_q.len - LW'(1);
          end
          s_d.pend = 1'b1;
          s_d.cport = s_q.act;
          s_d.oport = s_q.act;
          s_d.rdp = '0;
          s_d.st = P_HOLD;
        end
      end
      P_DATA: begin
        if (stb[0]) begin
          s_d.uvalid = 1'b1;
          s_d.udata = rb;
        end else if (gev[0]) begin
          s_d.st = P_IDLE;
        end
      end
      P_HOLD: begin
        if (s_q.done) begin
          s_d.pend = 1'b0;
          s_d.st = P_SKIP;
        end
      end
      default: s_d.st = P_SKIP;
    endcase
    if (s_q.forced) s_d.uvalid = 1'b0;

    case (s_q.ts)
      T_IDLE: begin
        if (fire && s_q.hw_ok) begin
          s_d.hw_ok = 1'b0;
          s_d.sw = 1'b0;
          s_d.ts = T_K;
        end else if (fire) begin
          s_d.slot_v = 1'b0;
          s_d.prevb = s_q.slot[7:0];
          s_d.sw = 1'b1;
          if (s_q.slot[RESP_LAST]) begin
            if (!s_q.crlf_en ||
                (s_q.prevb == CH_CR && s_q.slot[7:0] == CH_LF)) begin
              s_d.done = 1'b1;
            end else begin
              s_d.ts = T_CR;
            end
          end
        end
      end
      T_K: if (fire) s_d.ts = s_q.crlf_en ? T_CR : T_IDLE;
      T_CR: if (fire) s_d.ts = T_LF;
      default: begin
        if (fire) begin
          s_d.ts = T_IDLE;
          s_d.done = s_q.sw;
        end
      end
    endcase

    s_d.ack = (avs_read_i || avs_write_i) && !s_q.ack && !busy_slot;
    if (!s_q.ack) begin
      if (avs_address_i == OFS_CTRL) s_d.rdata = ctrl_w;
      else if (avs_address_i == OFS_STAT) s_d.rdata = stat_w;
      else if (avs_address_i == OFS_CMD) s_d.rdata = cmd_w;
      else s_d.rdata = '0;
    end
    if (s_q.ack && avs_write_i) begin
      if (avs_address_i == OFS_CTRL) begin
        s_d.cmd_en = avs_writedata_i[CTRL_EN];
        s_d.crlf_en = avs_writedata_i[CTRL_CRLF];
        s_d.aux_en = avs_writedata_i[CTRL_AUX];
        s_d.gap_len = (avs_writedata_i[CTRL_GAP +: 8] < GAP_MIN) ?
                      GAP_MIN : avs_writedata_i[CTRL_GAP +: 8];
      end else if (avs_address_i == OFS_RESP) begin
        s_d.slot = avs_writedata_i[8:0];
        s_d.slot_v = 1'b1;
      end
    end
    if (s_q.ack && avs_read_i && avs_address_i == OFS_CMD &&
        s_q.rdp < s_q.len) begin
      s_d.rdp = s_q.rdp + LW'(1);
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
      s_q.cmd_en <= CTRL_EN_RST;
      s_q.crlf_en <= CTRL_CRLF_RST;
      s_q.aux_en <= CTRL_AUX_RST;
      s_q.gap_len <= GAP_RST;
      s_q.st <= P_SKIP;
      s_q.ts <= T_IDLE;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign avs_readdata_o = s_q.rdata;
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !s_q.ack;
  assign user_data_o = s_q.udata;
  assign user_valid_o = s_q.uvalid;
  assign radio_suspend_o = s_q.forced;
  assign reboot_o = s_q.reboot;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  sequence s_third_plus;
    ce_i && s_q.st == P_FIRST && gev[s_q.act] && !stb[s_q.act] &&
      s_q.first == CH_PLUS && s_q.plus == SEQ_LAST;
  endsequence
  sequence s_third_minus;
    ce_i && s_q.st == P_FIRST && gev[s_q.act] && !stb[s_q.act] &&
      s_q.first == CH_MINUS && s_q.minus == SEQ_LAST && s_q.forced;
  endsequence

  a_plus_enters: assert property (s_third_plus |=>
    radio_suspend_o && s_q.hw_ok) else $error("no forced mode entry");
  a_minus_exits: assert property (s_third_minus |=>
    !radio_suspend_o && reboot_o) else $error("no forced mode exit");
  a_exit_reset: assert property ($fell(radio_suspend_o) |-> reboot_o)
    else $error("exit without reset request");
  a_forced_cmds: assert property (radio_suspend_o |-> cmd_on &&
    !user_valid_o) else $error("forced mode leaks user data");
  a_gap_capped: assert property (gap_cyc <= CAP[23:0] &&
    (gap_cyc == CAP[23:0] || gap_cyc >= 24'(3 * CHAR_BITS * BIT_CYC)))
    else $error("gap threshold out of range");
  a_cr_stripped: assert property (ce_i && s_q.st == P_CMD &&
    !stb[s_q.act] && gev[s_q.act] && lastb == CH_CR |=>
    s_q.len == $past(s_q.len) - LW'(1)) else $error("CR kept");
  a_aux_gated: assert property (ce_i && s_q.st == P_IDLE &&
    !s_q.aux_en && !stb[0] |=> s_q.st == P_IDLE)
    else $error("aux frame taken while off");
  a_crlf_tail: assert property (ce_i && fire && s_q.ts == T_CR |=>
    s_q.ts == T_LF ##1 (s_q.ts == T_LF)[*1]) else $error("LF skipped");
  a_off_is_data: assert property (ce_i && s_q.st == P_FIRST &&
    !cmd_on && !s_q.act && stb[0] |=> user_valid_o ##1 user_valid_o)
    else $error("byte not passed as data");
endmodule

/* sscp_tx.sv */
// serial transmitter for one response port
`timescale 1ns/1ps
module sscp_tx import sscp_pkg::*; #(
  parameter int BIT_CYC = BIT_CYC_DEF
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire logic [7:0] data_i,
  input wire logic valid_i,
  output logic ready_o,
  output logic line_o
);
  localparam logic [15:0] FULL = 16'(BIT_CYC - 1);
  typedef struct packed {
    logic [9:0] sh;
    logic [3:0] n;
    logic [15:0] div;
    logic busy;
  } sscp_txs_t;
  sscp_txs_t s_q, s_d;

  always_comb begin
    s_d = s_q;
    if (!s_q.busy) begin
      if (valid_i) begin
        s_d.sh = {1'b1, data_i, 1'b0};
        s_d.busy = 1'b1;
        s_d.div = FULL;
        s_d.n = 4'h0;
      end
    end else if (s_q.div != 16'h0) begin
      s_d.div = s_q.div - 16'h1;
    end else begin
      s_d.div = FULL;
      s_d.sh = {1'b1, s_q.sh[9:1]};
      s_d.n = s_q.n + 4'h1;
      if (s_q.n == 4'h9) begin
        s_d.busy = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
      s_q.sh <= 10'h3ff;
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign ready_o = !s_q.busy;
  assign line_o = s_q.sh[0];
endmodule

/* tb_sscp_top.sv */
// self-checking bench of the setup command parser
`timescale 1ns/1ps
module tb_sscp_top;
  import sscp_pkg::*;
  logic clk_i, nrst_i, ce_i, l0, l1, s0, s1, wq, uv, sus, boot;
  logic [4:0] avs_address_i;
  logic avs_read_i, avs_write_i;
  logic [31:0] avs_writedata_i, avs_readdata_o, rd;
  logic [7:0] ud, g0, g1, r0, r1;
  logic m0, m1;
  logic [7:0] q_u[$], q_0[$], q_1[$];
  int n_fail, check_count, n_boot;

  sscp_top #(.BIT_CYC(4), .GAP_CAP_CYC(200)) u_dut (.clk_i(clk_i),
    .nrst_i(nrst_i), .ce_i(ce_i), .host_to_module_line_i(l0),
    .module_to_host_line_o(m0), .auxiliary_host_to_module_line_i(l1),
    .auxiliary_module_to_host_line_o(m1), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(wq), .user_data_o(ud), .user_valid_o(uv),
    .radio_suspend_o(sus), .reboot_o(boot));
  sscp_host u_h0 (.clk_i(clk_i), .line_o(l0),
    .line_i(m0), .got_o(g0), .got_stb_o(s0));
  sscp_host u_h1 (.clk_i(clk_i), .line_o(l1),
    .line_i(m1), .got_o(g1), .got_stb_o(s1));

  task automatic summarize();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic to();
    n_fail++;
    summarize();
  endtask
  task automatic chk(input string w, input logic [31:0] s, e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", w, e, s);
    end
  endtask
  function automatic logic [7:0] pop(ref logic [7:0] q[$]);
    if (q.size() == 0)
      return 8'hxx;
    return q.pop_front();
  endfunction

  always @(negedge clk_i) begin
    if (uv === 1'b1)
      chk("user", {24'h0, ud}, {24'h0, pop(q_u)});
    if (s0 === 1'b1)
      chk("resp0", {24'h0, g0}, {24'h0, pop(q_0)});
    if (s1 === 1'b1)
      chk("resp1", {24'h0, g1}, {24'h0, pop(q_1)});
    if (boot === 1'b1)
      n_boot++;
  end

  task automatic bus(input logic w, input logic [4:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_write_i <= w;
    avs_read_i <= !w;
    @(posedge clk_i);
    while (wq !== 1'b0 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 200)
      to();
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic frame(input bit aux, input logic [7:0] b[$]);
    foreach (b[i]) begin
      if (aux)
        u_h1.send(b[i]);
      else
        u_h0.send(b[i]);
    end
    u_h0.idle(4);
  endtask
  task automatic resp(input logic [7:0] b[$]);
    foreach (b[i])
      bus(1'b1, OFS_RESP, {23'h0, i == b.size() - 1, b[i]});
  endtask
  // bounded wait for every noted result
  task automatic drain();
    int n;
    n = 0;
    while (q_u.size() + q_0.size() + q_1.size() != 0 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 4000)
      to();
    u_h0.idle(4);
  endtask
  task automatic pend();
    int n;
    n = 0;
    rd = 32'h0;
    while (rd[0] !== 1'b1 && n < 200) begin
      bus(1'b0, OFS_STAT, 32'h0);
      n++;
    end
    if (n >= 200)
      to();
  endtask

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  initial begin
    nrst_i = 1'b0;
    ce_i = 1'b1;
    avs_address_i = 5'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    n_fail = 0;
    check_count = 0;
    n_boot = 0;
    void'($urandom(32'h692e));
    r0 = 8'h30 + 8'($urandom % 10);
    r1 = 8'h30 + 8'($urandom % 10);
    repeat (20) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    chk("suspend", {31'h0, sus}, 32'h0);
    ce_i <= 1'b0;
    fork
      repeat (6) @(posedge clk_i);
      bus(1'b0, OFS_STAT, 32'h0);
    join_any
    chk("frozen", {31'h0, wq}, 32'h1);
    ce_i <= 1'b1;
    wait fork;
    chk("stat", rd, 32'h0);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", rd, 32'h0000_0303);
    bus(1'b1, OFS_CTRL, 32'h0000_0102);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", rd, 32'h0000_0302);
    bus(1'b0, 5'h10, 32'h0);
    chk("unmapped", rd, 32'h0);
    $display("test registers done");
    u_h0.idle(4);
    q_u = {CH_S, CH_L, r0};
    frame(1'b0, {CH_S, CH_L, r0});
    drain();
    $display("test user data done");
    bus(1'b1, OFS_CTRL, 32'h0000_0303);
    frame(1'b0, {CH_S, CH_L, r1, CH_CR, CH_LF});
    pend();
    chk("status", rd, 32'h0000_0301);
    q_u.delete();
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, OFS_CMD, 32'h0);
      chk("cmd", rd, {23'h0, 1'b1, i == 0 ? CH_S : i == 1 ? CH_L : r1});
    end
    q_0 = {CH_O, CH_K, CH_CR, CH_LF};
    resp({CH_O, CH_K});
    drain();
    $display("test primary command done");
    bus(1'b1, OFS_CTRL, 32'h0000_0307);
    frame(1'b1, {CH_S, CH_L, r0, CH_CR});
    pend();
    chk("status", rd, 32'h0000_0303);
    q_1 = {CH_O, CH_K, CH_CR, CH_LF};
    resp({CH_O, CH_K, CH_CR, CH_LF});
    drain();
    bus(1'b0, OFS_STAT, 32'h0);
    chk("pend", {31'h0, rd[0]}, 32'h0);
    $display("test aux command done");
    bus(1'b1, OFS_CTRL, 32'h0000_0302);
    q_0 = {CH_O, CH_K, CH_CR, CH_LF};
    repeat (3) frame(1'b0, {CH_PLUS});
    drain();
    chk("suspend", {31'h0, sus}, 32'h1);
    bus(1'b0, OFS_STAT, 32'h0);
    chk("forced", {31'h0, rd[STAT_FORCED]}, 32'h1);
    q_0 = {CH_O, CH_K, CH_CR, CH_LF};
    repeat (3) frame(1'b0, {CH_MINUS});
    drain();
    chk("suspend", {31'h0, sus}, 32'h0);
    chk("reboot", n_boot, 32'h1);
    q_u = {CH_S, CH_L};
    frame(1'b0, {CH_S, CH_L});
    drain();
    $display("test forced mode done");
    bus(1'b1, OFS_CTRL, 32'h0000_0301);
    frame(1'b0, {CH_S, CH_L, r0});
    pend();
    chk("status", rd, 32'h0000_0301);
    q_0 = {CH_O, CH_K};
    resp({CH_O, CH_K});
    drain();
    $display("test bare answer done");
    summarize();
  end
endmodule
